/* File: rtl/tpa_acq_ctrl.sv */
// acquisition control: i2c registers, sequencer, row readout, modulator
`timescale 1ns/1ps
`default_nettype none
module tpa_acq_ctrl #(
  parameter logic [6:0] I2C_ADDR = 7'h22  // arbitrary value
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        clk_mod_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        shutter_i,
  output logic             pix_rd_o,
  output logic [6:0]       pix_row_o,
  output logic [7:0]       pix_col_o,
  input  wire logic [11:0] pix_gate_a_i,
  input  wire logic [11:0] pix_gate_b_i,
  input  wire logic        pix_sat_i,
  output logic [11:0]      video_data_o,
  output logic             video_valid_o,
  output logic             line_sync_o,
  output logic             frame_sync_o,
  output logic             sync_saturation_pin_o,
  output logic             busy_o,
  output logic             led_mod_o,
  output logic [1:0]       even_row_demod_group_o,
  output logic [1:0]       odd_row_demod_group_o
);
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_PTR, I_WDATA, I_ACK, I_RDATA, I_RACK
  } tpa_i2c_st_t;
  typedef enum logic [1:0] {A_IDLE, A_INTEG, A_CONV, A_LINE} tpa_acq_st_t;

  typedef struct packed {
    logic [1:0]                  scl_s, sda_s, shut_s;
    logic                        scl_d, sda_d, shut_d;
    tpa_i2c_st_t                 ist;
    tpa_i2c_st_t                 iret;
    logic [3:0]                  ibits;
    logic [7:0]                  isr, iptr;
    logic                        irw, inack, sda_oe;
    logic [255:0][7:0]           regs;
    tpa_acq_st_t                 ast;
    logic [1:0]                  sample;
    logic [19:0]                 tcnt;
    logic [6:0]                  row;
    logic [7:0]                  pidx, cap_idx;
    logic                        cap;
    logic [159:0][12:0]          rowbuf;
    logic                        en_even, en_odd;
    tpa_pkg::tpa_modcfg_t        modcfg;
    logic                        pix_rd;
    logic [6:0]                  pix_row;
    logic [7:0]                  pix_col;
    logic [11:0]                 vdata;
    logic                        vvalid, lsync, fsync, syncsat, busy;
  } tpa_sys_t;

  typedef struct packed {
    logic [1:0]                  rst_s;
    logic [2:0]                  ee, eo;
    logic [1:0][4:0]             cfg;
    logic [1:0]                  cnt;
    logic                        led;
    logic [1:0]                  ev, od;
  } tpa_mod_t;

  tpa_sys_t s, next_s;
  tpa_mod_t m, next_m;

  // registers the host may write
  function automatic logic writable(input logic [7:0] a);
    writable = (a >= tpa_pkg::REG_MOD_FIRST && a <= tpa_pkg::REG_MOD_LAST)
      || a == tpa_pkg::REG_SAMPLES || a == tpa_pkg::REG_ADC_RES
      || a == tpa_pkg::REG_INT2_HI || a == tpa_pkg::REG_INT2_LOW
      || a == tpa_pkg::REG_INT1_HI || a == tpa_pkg::REG_INT1_LOW
      || a == tpa_pkg::REG_VID_FMT || a == tpa_pkg::REG_PIN_OPT
      || a == tpa_pkg::REG_ADC_CTRL || a == tpa_pkg::REG_ROW_MODE;
  endfunction : writable

  // reset image of the register file
  function automatic logic [7:0] reset_val(input logic [7:0] a);
    case (a)
      tpa_pkg::REG_INT1_HI, tpa_pkg::REG_INT2_HI: begin
        reset_val = tpa_pkg::RST_INT_HI;
      end
      tpa_pkg::REG_SAMPLES:  reset_val = tpa_pkg::RST_SAMPLES;
      tpa_pkg::REG_ADC_CTRL: reset_val = tpa_pkg::ADC_CTRL_12B;
      tpa_pkg::REG_ADC_RES:  reset_val = tpa_pkg::ADC_RES_12B;
      default:               reset_val = tpa_pkg::RST_INT_LOW;
    endcase
  endfunction : reset_val

  // decoded configuration
  logic        adc8, fmt8, repurpose, force_sat, dual_phase, dual_int;
  logic [19:0] len1_cyc, len2_cyc, conv_cyc;
  logic [1:0]  last_sample;
  always_comb begin
    adc8 = s.regs[tpa_pkg::REG_ADC_CTRL] == tpa_pkg::ADC_CTRL_8B
      && s.regs[tpa_pkg::REG_ADC_RES] == tpa_pkg::ADC_RES_8B;
    conv_cyc = adc8 ? tpa_pkg::CONV_8B_CYC : tpa_pkg::CONV_12B_CYC;
    fmt8 = s.regs[tpa_pkg::REG_VID_FMT][tpa_pkg::FMT_LSB +: 2]
      == tpa_pkg::FMT_8BIT;
    repurpose = s.regs[tpa_pkg::REG_PIN_OPT][tpa_pkg::PIN_REPURPOSE_BIT];
    force_sat = s.regs[tpa_pkg::REG_PIN_OPT][tpa_pkg::PIN_FORCE_SAT_BIT];
    // code 3 falls back to full resolution so one mode always rules
    dual_phase = s.regs[tpa_pkg::REG_ROW_MODE][1:0]
      == tpa_pkg::MODE_DUAL_PHASE;
    dual_int = s.regs[tpa_pkg::REG_ROW_MODE][1:0]
      == tpa_pkg::MODE_DUAL_INT;
    len1_cyc = 20'({s.regs[tpa_pkg::REG_INT1_HI],
      s.regs[tpa_pkg::REG_INT1_LOW]} * tpa_pkg::INT_UNIT_CYC);
    len2_cyc = dual_int ? 20'({s.regs[tpa_pkg::REG_INT2_HI],
      s.regs[tpa_pkg::REG_INT2_LOW]} * tpa_pkg::INT_UNIT_CYC)
      : len1_cyc;
    case (s.regs[tpa_pkg::REG_SAMPLES][1:0])
      tpa_pkg::CNT_ONE: last_sample = 2'h0;
      tpa_pkg::CNT_TWO: last_sample = 2'h1;
      default:          last_sample = 2'h3;
    endcase
  end

  // live status byte: busy and current sample
  logic [7:0] status;
  assign status = {5'h00, s.sample, s.busy};

  // read side of the register map, unmapped reads as zero
  function automatic logic [7:0] rd_val(input tpa_sys_t c,
                                        input logic [7:0] a,
                                        input logic [7:0] st);
    if (a == tpa_pkg::REG_STATUS) begin
      rd_val = st;
    end else if (writable(a)) begin
      rd_val = c.regs[a];
    end else begin
      rd_val = 8'h00;
    end
  endfunction : rd_val

  // pixel conversion: clamp a-b into signed 12 bits
  logic signed [12:0] diff;
  tpa_pkg::tpa_pix_t  cap_pix;
  always_comb begin
    diff = $signed({1'b0, pix_gate_a_i}) - $signed({1'b0, pix_gate_b_i});
    cap_pix.sat = pix_sat_i;
    if (diff > 13'sh07ff) begin
      cap_pix.value = 12'h7ff;
    end else if (diff < -13'sh0800) begin
      cap_pix.value = 12'h800;
    end else begin
      cap_pix.value = diff[11:0];
    end
    // reduced adc resolution leaves the low nibble unresolved
    if (adc8) begin
      cap_pix.value = cap_pix.value & tpa_pkg::LOW4_MASK;
    end
  end

  // video word of the pixel being shifted out
  tpa_pkg::tpa_pix_t out_pix;
  logic [11:0]       out_word;
  always_comb begin
    out_pix = s.rowbuf[s.pidx];
    out_word = out_pix.value;
    if (repurpose && force_sat && out_pix.sat) begin
      out_word = tpa_pkg::SAT_WORD;
    end
    if (fmt8) begin
      out_word = {4'h0, out_word[11:4]};
    end
  end

  logic scl_rise, scl_fall, i2c_start, i2c_stop, trig, shut_cmd;
  logic [7:0] col;
  // system domain next state
  always_comb begin
    next_s = s;
    // pin synchronisers, second stage feeds all logic
    next_s.scl_s  = {s.scl_s[0], scl_i};
    next_s.sda_s  = {s.sda_s[0], sda_i};
    next_s.shut_s = {s.shut_s[0], shutter_i};
    next_s.scl_d  = s.scl_s[1];
    next_s.sda_d  = s.sda_s[1];
    next_s.shut_d = s.shut_s[1];
    scl_rise  = s.scl_s[1] && !s.scl_d;
    scl_fall  = !s.scl_s[1] && s.scl_d;
    i2c_start = s.scl_s[1] && s.sda_d && !s.sda_s[1];
    i2c_stop  = s.scl_s[1] && !s.sda_d && s.sda_s[1];
    shut_cmd  = 1'b0;
    col       = 8'h00;

    // i2c slave: pointer byte, then write bytes or read bytes
    if (i2c_start) begin
      next_s.ist = tpa_i2c_st_t'(I_ADDR);
      next_s.ibits = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (i2c_stop) begin
      next_s.ist = tpa_i2c_st_t'(I_IDLE);
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.ist)
        I_ADDR, I_PTR, I_WDATA: begin
          if (scl_rise) begin
            next_s.isr = {s.isr[6:0], s.sda_s[1]};
            next_s.ibits = s.ibits + 4'h1;
          end else if (scl_fall && s.ibits == 4'h8) begin
            next_s.ibits = 4'h0;
            next_s.ist = tpa_i2c_st_t'(I_ACK);
            next_s.sda_oe = 1'b1;
            next_s.iret = s.ist;
            if (s.ist == I_ADDR) begin
              next_s.irw = s.isr[0];
              if (s.isr[7:1] != I2C_ADDR) begin
                next_s.ist = tpa_i2c_st_t'(I_IDLE);
                next_s.sda_oe = 1'b0;
              end
            end else if (s.ist == I_PTR) begin
              next_s.iptr = s.isr;
            end else begin
              if (writable(s.iptr)) begin
                next_s.regs[s.iptr] = s.isr;
              end
              shut_cmd = s.iptr == tpa_pkg::REG_SHUTTER && s.isr[0];
              next_s.iptr = s.iptr + 8'h01;
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'b0;
            next_s.ist = tpa_i2c_st_t'(I_WDATA);
            if (s.iret == I_ADDR && !s.irw) begin
              next_s.ist = tpa_i2c_st_t'(I_PTR);
            end else if (s.iret == I_ADDR) begin
              next_s.ist = tpa_i2c_st_t'(I_RDATA);
              next_s.isr = rd_val(s, s.iptr, status);
              next_s.sda_oe = !next_s.isr[7];
              next_s.iptr = s.iptr + 8'h01;
            end
          end
        end
        I_RDATA: begin
          if (scl_fall) begin
            next_s.ibits = s.ibits + 4'h1;
            next_s.isr = {s.isr[6:0], 1'b0};
            next_s.sda_oe = !s.isr[6];
            if (s.ibits == 4'h7) begin
              next_s.ibits = 4'h0;
              next_s.sda_oe = 1'b0;
              next_s.ist = tpa_i2c_st_t'(I_RACK);
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            next_s.inack = s.sda_s[1];
          end else if (scl_fall) begin
            next_s.ist = tpa_i2c_st_t'(I_IDLE);
            if (!s.inack) begin
              next_s.ist = tpa_i2c_st_t'(I_RDATA);
              next_s.isr = rd_val(s, s.iptr, status);
              next_s.sda_oe = !next_s.isr[7];
              next_s.iptr = s.iptr + 8'h01;
            end
          end
        end
        default: next_s.ist = tpa_i2c_st_t'(I_IDLE);
      endcase
    end

    // acquisition sequencer
    trig = (s.shut_s[1] && !s.shut_d) || shut_cmd;
    next_s.pix_rd  = 1'b0;
    next_s.vvalid  = 1'b0;
    next_s.lsync   = 1'b0;
    next_s.syncsat = 1'b0;
    next_s.cap     = s.pix_rd;
    next_s.cap_idx = s.pix_col - tpa_pkg::X_FIRST;
    if (s.cap) begin
      next_s.rowbuf[s.cap_idx] = cap_pix;
    end
    case (s.ast)
      A_IDLE: begin
        // a trigger during a sequence is simply not looked at
        if (trig) begin
          next_s.ast = tpa_acq_st_t'(A_INTEG);
          next_s.busy = 1'b1;
          next_s.sample = 2'h0;
          next_s.tcnt = 20'h00000;
        end
      end
      A_INTEG: begin
        // config copy taken every integration cycle: host edits land at once, held through readout
        next_s.modcfg.trim = s.regs[tpa_pkg::REG_MOD_FIRST][1:0];
        next_s.modcfg.dual_phase = dual_phase;
        next_s.modcfg.sample = dual_phase ? {s.sample[0], 1'b0}
                                          : s.sample;
        next_s.tcnt = s.tcnt + 20'h00001;
        next_s.en_even = s.tcnt < len1_cyc;
        next_s.en_odd  = s.tcnt < len2_cyc;
        if (s.tcnt >= len1_cyc && s.tcnt >= len2_cyc) begin
          next_s.ast = tpa_acq_st_t'(A_CONV);
          next_s.row = tpa_pkg::Y_LAST;
          next_s.tcnt = 20'h00000;
          next_s.pidx = 8'h00;
          next_s.fsync = 1'b1;
        end
      end
      A_CONV: begin
        next_s.tcnt = s.tcnt + 20'h00001;
        if (s.pidx < 8'(tpa_pkg::ACT_W)) begin
          // even columns first, odd columns after
          if (s.pidx < 8'(tpa_pkg::HALF_W)) begin
            col = tpa_pkg::X_FIRST + {s.pidx[6:0], 1'b0};
          end else begin
            col = tpa_pkg::X_FIRST + 8'h01
              + {7'(s.pidx - 8'(tpa_pkg::HALF_W)), 1'b0};
          end
          next_s.pix_rd = 1'b1;
          next_s.pix_row = s.row;
          next_s.pix_col = col;
          next_s.pidx = s.pidx + 8'h01;
        end
        if (s.tcnt == conv_cyc - 20'h00001) begin
          next_s.ast = tpa_acq_st_t'(A_LINE);
          next_s.pidx = 8'h00;
        end
      end
      A_LINE: begin
        next_s.vvalid = 1'b1;
        next_s.lsync = 1'b1;
        next_s.vdata = out_word;
        next_s.syncsat = repurpose ? 1'b1 : out_pix.sat;
        next_s.pidx = s.pidx + 8'h01;
        if (s.pidx == 8'(tpa_pkg::ACT_W - 1)) begin
          next_s.pidx = 8'h00;
          next_s.tcnt = 20'h00000;
          if (s.row != tpa_pkg::Y_FIRST) begin
            next_s.row = s.row - 7'h01;
            next_s.ast = tpa_acq_st_t'(A_CONV);
          end else if (s.sample == last_sample) begin
            next_s.fsync = 1'b0;
            next_s.busy = 1'b0;
            next_s.ast = tpa_acq_st_t'(A_IDLE);
          end else begin
            next_s.fsync = 1'b0;
            next_s.sample = s.sample + 2'h1;
            next_s.ast = tpa_acq_st_t'(A_INTEG);
          end
        end
      end
      default: next_s.ast = tpa_acq_st_t'(A_IDLE);
    endcase
    if (s.ast != A_INTEG) begin
      next_s.en_even = 1'b0;
      next_s.en_odd = 1'b0;
    end

    if (rst_i) begin
      next_s = '0;
      next_s.ist = tpa_i2c_st_t'(I_IDLE);
      next_s.iret = tpa_i2c_st_t'(I_IDLE);
      next_s.ast = tpa_acq_st_t'(A_IDLE);
      // bus pins idle high, so no false edge once reset lets go
      next_s.scl_s = 2'h3;
      next_s.sda_s = 2'h3;
      next_s.scl_d = 1'b1;
      next_s.sda_d = 1'b1;
      for (int i = 0; i < 256; i++) begin
        next_s.regs[i] = reset_val(8'(i));
      end
    end
  end

  // system domain register
  always_ff @(posedge clk_sys_i) begin
    s <= next_s;
  end

  // modulation domain: light and both row groups from one counter
  logic [1:0]           ph, ph_led, ph_odd;
  tpa_pkg::tpa_modcfg_t mc;
  always_comb begin
    next_m = m;
    next_m.rst_s = {m.rst_s[0], rst_i};
    // enables one stage later than the config word, so it has settled
    next_m.ee  = {m.ee[1:0], s.en_even};
    next_m.eo  = {m.eo[1:0], s.en_odd};
    next_m.cfg = {m.cfg[0], s.modcfg};
    mc = tpa_pkg::tpa_modcfg_t'(m.cfg[1]);
    // four 40 MHz steps give a 10 MHz square wave at half duty
    next_m.cnt = m.cnt + 2'h1;
    ph = m.cnt + mc.trim;
    ph_led = ph - {1'b0, mc.sample[0]};
    // odd rows one quarter later carry the next sample
    ph_odd = mc.dual_phase ? ph - 2'h1 : ph;
    next_m.led = (m.ee[2] || m.eo[2]) && ph_led[1];
    next_m.ev = m.ee[2] ? {~(ph[1] ^ mc.sample[1]), ph[1] ^ mc.sample[1]}
                        : 2'h0;
    next_m.od = m.eo[2] ? {~(ph_odd[1] ^ mc.sample[1]),
                           ph_odd[1] ^ mc.sample[1]} : 2'h0;
    if (m.rst_s[1]) begin
      next_m.cnt = 2'h0;
      next_m.led = 1'b0;
      next_m.ev = 2'h0;
      next_m.od = 2'h0;
    end
  end

  // modulation domain register
  always_ff @(posedge clk_mod_i) begin
    m <= next_m;
  end

  // outputs straight from flip-flops, except sda_o tied low
  assign sda_o                  = 1'b0;
  assign sda_oe_o               = s.sda_oe;
  assign pix_rd_o               = s.pix_rd;
  assign pix_row_o              = s.pix_row;
  assign pix_col_o              = s.pix_col;
  assign video_data_o           = s.vdata;
  assign video_valid_o          = s.vvalid;
  assign line_sync_o            = s.lsync;
  assign frame_sync_o           = s.fsync;
  assign sync_saturation_pin_o  = s.syncsat;
  assign busy_o                 = s.busy;
  assign led_mod_o              = m.led;
  assign even_row_demod_group_o = m.ev;
  assign odd_row_demod_group_o  = m.od;
endmodule : tpa_acq_ctrl
`default_nettype wire

/* File: shared/tpa_pkg.sv */
// constants and carrier types of the time-of-flight acquisition control
package tpa_pkg;
  // pixel field geometry
  localparam int ARRAY_W = 168;
  localparam int ARRAY_H = 72;
  localparam int ACT_W   = 160;
  localparam int ACT_H   = 60;
  localparam int HALF_W  = 80;
  localparam logic [7:0] X_FIRST = 8'h04;
  localparam logic [6:0] Y_FIRST = 7'h06;
  localparam logic [6:0] Y_LAST  = 7'h41;
  // register offsets
  localparam logic [7:0] REG_MOD_FIRST  = 8'h22;
  localparam logic [7:0] REG_MOD_LAST   = 8'h2d;
  localparam logic [7:0] REG_SAMPLES    = 8'h92;
  localparam logic [7:0] REG_ADC_RES    = 8'h9d;
  localparam logic [7:0] REG_INT2_HI    = 8'h9e;
  localparam logic [7:0] REG_INT2_LOW   = 8'h9f;
  localparam logic [7:0] REG_INT1_HI    = 8'ha2;
  localparam logic [7:0] REG_INT1_LOW   = 8'ha3;
  localparam logic [7:0] REG_VID_FMT    = 8'hcb;
  localparam logic [7:0] REG_PIN_OPT    = 8'hcc;
  localparam logic [7:0] REG_ADC_CTRL   = 8'hcd;
  localparam logic [7:0] REG_ROW_MODE   = 8'he0;
  localparam logic [7:0] REG_SHUTTER    = 8'he1;
  localparam logic [7:0] REG_STATUS     = 8'he2;
  // reset values and 8 bit adc codes
  localparam logic [7:0] RST_INT_HI     = 8'h02;
  localparam logic [7:0] RST_INT_LOW    = 8'h00;
  localparam logic [7:0] RST_SAMPLES    = 8'h02;
  localparam logic [7:0] ADC_CTRL_8B    = 8'h1b;
  localparam logic [7:0] ADC_RES_8B     = 8'h34;
  localparam logic [7:0] ADC_CTRL_12B   = 8'h13;
  localparam logic [7:0] ADC_RES_12B    = 8'h50;
  // field positions and codes
  localparam int PIN_REPURPOSE_BIT = 6;
  localparam int PIN_FORCE_SAT_BIT = 7;
  localparam int FMT_LSB           = 4;
  localparam logic [1:0] FMT_8BIT  = 2'h3;
  localparam logic [1:0] CNT_ONE   = 2'h0;
  localparam logic [1:0] CNT_TWO   = 2'h1;
  localparam logic [1:0] MODE_DUAL_PHASE = 2'h1;
  localparam logic [1:0] MODE_DUAL_INT   = 2'h2;
  localparam logic [11:0] SAT_WORD = 12'hfff;
  localparam logic [11:0] LOW4_MASK = 12'hff0;
  // timing
  localparam int SYS_PERIOD_NS = 10;
  localparam int CONV_8B_NS    = 24500;
  localparam int CONV_12B_NS   = 31500;
  localparam int INT_UNIT_NS   = 100;
  localparam logic [19:0] CONV_8B_CYC =
    20'((CONV_8B_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [19:0] CONV_12B_CYC =
    20'((CONV_12B_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [3:0] INT_UNIT_CYC =
    4'((INT_UNIT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  // one converted pixel
  typedef struct packed {
    logic        sat;
    logic [11:0] value;
  } tpa_pix_t;
  // quasi-static modulator setup handed to the modulation clock
  typedef struct packed {
    logic [1:0] trim;
    logic       dual_phase;
    logic [1:0] sample;
  } tpa_modcfg_t;
endpackage : tpa_pkg

/* File: tb/tpa_acq_asserts.sv */
// port assertions of the acquisition control
`timescale 1ns/1ps
`default_nettype none
module tpa_acq_asserts (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       clk_mod_i,
  input wire logic       pix_rd_o,
  input wire logic [6:0] pix_row_o,
  input wire logic [7:0] pix_col_o,
  input wire logic       video_valid_o,
  input wire logic       line_sync_o,
  input wire logic       frame_sync_o,
  input wire logic       sync_saturation_pin_o,
  input wire logic       busy_o,
  input wire logic       shutter_i,
  input wire logic       led_mod_o,
  input wire logic [1:0] even_row_demod_group_o,
  input wire logic [1:0] odd_row_demod_group_o
);
  logic [7:0] run;
  logic [7:0] lcol;
  logic [6:0] lrow;
  // line length counter and last read address, restart at row 65
  always_ff @(posedge clk_sys_i) begin
    run <= (line_sync_o && !rst_i) ? run + 8'h01 : 8'h00;
    lcol <= rst_i ? 8'h00 : (pix_rd_o ? pix_col_o : lcol);
    lrow <= rst_i ? 7'h41 : (pix_rd_o ? pix_row_o : lrow);
  end
  a_rd_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pix_rd_o |-> pix_row_o inside {[7'h06:7'h41]} &&
    pix_col_o inside {[8'h04:8'ha3]}) else $error("read outside field");
  a_row_order: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pix_rd_o |-> pix_row_o == lrow || pix_row_o == lrow - 7'h01 ||
    pix_row_o == 7'h41) else $error("row order broken");
  a_col_step: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pix_rd_o && lcol >= 8'h04 && lcol <= 8'ha1 |-> pix_col_o == lcol + 8'h02)
    else $error("column step broken");
  a_col_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pix_rd_o && lcol == 8'ha2 |-> pix_col_o == 8'h05)
    else $error("odd columns not after even");
  a_line_len: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(line_sync_o) |-> run == 8'ha0) else $error("line not 160 words");
  a_valid_line: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    video_valid_o |-> line_sync_o) else $error("word outside line");
  a_pin_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !line_sync_o |-> !sync_saturation_pin_o) else $error("pin active idle");
  a_busy_span: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pix_rd_o || frame_sync_o |-> busy_o) else $error("activity while idle");
  a_trig_busy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(shutter_i) && !busy_o |-> ##[1:8] busy_o)
    else $error("shutter not taken");
  a_led_duty: assert property (@(posedge clk_mod_i) disable iff (rst_i)
    led_mod_o [*2] |=> !led_mod_o) else $error("led high too long");
  a_gate_even: assert property (@(posedge clk_mod_i) disable iff (rst_i)
    even_row_demod_group_o[0] |-> !even_row_demod_group_o[1])
    else $error("even row gates both on");
  a_gate_odd: assert property (@(posedge clk_mod_i) disable iff (rst_i)
    odd_row_demod_group_o[0] |-> !odd_row_demod_group_o[1])
    else $error("odd row gates both on");
  c_busy: cover property (@(posedge clk_sys_i) $rose(busy_o));
  c_line: cover property (@(posedge clk_sys_i) $fell(line_sync_o));
  c_wrap: cover property (@(posedge clk_sys_i) pix_rd_o && lcol == 8'ha2);
endmodule : tpa_acq_asserts
bind tpa_acq_ctrl tpa_acq_asserts u_chk (.clk_sys_i, .rst_i, .clk_mod_i,
  .pix_rd_o, .pix_row_o, .pix_col_o, .video_valid_o, .line_sync_o,
  .frame_sync_o, .sync_saturation_pin_o, .busy_o, .shutter_i, .led_mod_o,
  .even_row_demod_group_o, .odd_row_demod_group_o);
`default_nettype wire

/* File: tb/tpa_acq_ctrl_test.sv */
// bench: i2c register access, shutter runs, row readout checks
`timescale 1ns/1ps
`default_nettype none
module tpa_acq_ctrl_test;
  localparam logic [6:0] DEV = 7'h22;  // arbitrary, design default
  logic clk_sys_i = 1'b0;
  logic clk_mod_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl = 1'b1;
  logic sda_drv = 1'b1;
  logic shutter = 1'b0;
  logic sda_oe, pix_rd, vvalid, lsync, spin, gsat;
  logic [6:0] row;
  logic [7:0] col;
  logic [11:0] ga, gb, vdata;
  wire sda_line = sda_drv & ~sda_oe;  // open drain with pull-up
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // sys clock 10 ns; mod clock 160 ns, offset so edges never align
  initial forever #5 clk_sys_i = ~clk_sys_i;
  initial begin
    #3;
    forever #80 clk_mod_i = ~clk_mod_i;
  end
  tpa_acq_ctrl DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .clk_mod_i(clk_mod_i), .scl_i(scl), .sda_i(sda_line), .sda_o(),
    .sda_oe_o(sda_oe), .shutter_i(shutter), .pix_rd_o(pix_rd),
    .pix_row_o(row), .pix_col_o(col), .pix_gate_a_i(ga),
    .pix_gate_b_i(gb), .pix_sat_i(gsat), .video_data_o(vdata),
    .video_valid_o(vvalid), .line_sync_o(lsync), .frame_sync_o(),
    .sync_saturation_pin_o(spin), .busy_o(), .led_mod_o(),
    .even_row_demod_group_o(), .odd_row_demod_group_o());
  tpa_pix_model u_pix (.clk_i(clk_sys_i), .rd_i(pix_rd), .row_i(row),
    .col_i(col), .a_o(ga), .b_o(gb), .sat_o(gsat));
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // ceiling well above the two short runs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic hc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : hc
  // sda moves only while scl is low, two cycles clear of its edges
  task automatic ibit(input logic b, output logic r);
    sda_drv = b;
    hc(4);
    scl = 1'b1;
    hc(5);
    r = sda_line;
    scl = 1'b0;
    hc(2);
  endtask : ibit
  task automatic ibyte(input logic [7:0] d, input logic rd,
                       output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      ibit(d[i], r[i]);
    ibit(1'b1, a);
    if (!rd)
      chk(a, 1'b0);
  endtask : ibyte
  task automatic istart();
    sda_drv = 1'b1;
    hc(2);
    scl = 1'b1;
    hc(5);
    sda_drv = 1'b0;
    hc(5);
    scl = 1'b0;
    hc(2);
  endtask : istart
  task automatic istop();
    sda_drv = 1'b0;
    hc(2);
    scl = 1'b1;
    hc(5);
    sda_drv = 1'b1;
    hc(5);
  endtask : istop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    istart();
    ibyte({DEV, 1'b0}, 1'b0, r);
    ibyte(a, 1'b0, r);
    ibyte(d, 1'b0, r);
    istop();
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    istart();
    ibyte({DEV, 1'b0}, 1'b0, d);
    ibyte(a, 1'b0, d);
    istart();
    ibyte({DEV, 1'b1}, 1'b0, d);
    ibyte(8'hff, 1'b1, d);
    istop();
    chk(d, e);
  endtask : rc
  // first line is row 65; words in column order, then time to next line
  task automatic line_chk(input logic f8, input logic rep, input int per);
    int n;
    int t0;
    logic [11:0] d;
    logic [11:0] e;
    for (n = 0; lsync !== 1'b1 && n < 20000; n++)
      hc(1);
    t0 = cyc;
    for (int k = 0; k < 160; k++) begin
      d = 12'(k * 8 + 32) - 12'h410;
      if (rep && k == 96)
        d = 12'hfff;
      e = f8 ? {4'h0, d[11:4]} : d;
      chk(vvalid, 1'b1);
      chk(vdata, e);
      chk(spin, rep || k == 96);
      hc(1);
    end
    for (n = 0; lsync !== 1'b1 && n < 20000; n++)
      hc(1);
    chk(20'(cyc - t0), 20'(per));
  endtask : line_chk
  // main sequence: reset values, command shutter, pin shutter in 8 bit
  initial begin
    hc(20);
    rst_i = 1'b0;
    hc(5);
    rc(8'h92, 8'h02);
    rc(8'ha2, 8'h02);
    rc(8'ha3, 8'h00);
    wr(8'hf0, 8'h5a);
    rc(8'hf0, 8'h00);
    wr(8'h92, 8'h00);
    wr(8'ha2, 8'h00);
    wr(8'ha3, 8'h01);
    wr(8'he1, 8'h01);
    rc(8'he2, 8'h01);
    line_chk(1'b0, 1'b0, 3310);
    rst_i = 1'b1;
    hc(40);
    rst_i = 1'b0;
    hc(5);
    wr(8'hcd, 8'h1b);
    wr(8'h9d, 8'h34);
    wr(8'hcb, 8'h30);
    wr(8'hcc, 8'hc0);
    wr(8'h22, 8'h01);
    rc(8'h22, 8'h01);
    wr(8'he0, 8'h02);
    rc(8'he0, 8'h02);
    wr(8'h9e, 8'h00);
    wr(8'h9f, 8'h02);
    wr(8'h92, 8'h00);
    wr(8'ha2, 8'h00);
    wr(8'ha3, 8'h01);
    shutter = 1'b1;
    hc(30);
    shutter = 1'b0;
    line_chk(1'b1, 1'b1, 2610);
    end_sim();
  end
endmodule : tpa_acq_ctrl_test
`default_nettype wire

/* File: tb/tpa_pix_model.sv */
// pixel array model answering row reads with gate charges
`timescale 1ns/1ps
`default_nettype none
module tpa_pix_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [6:0]  row_i,
  input  wire logic [7:0]  col_i,
  output logic      [11:0] a_o,
  output logic      [11:0] b_o,
  output logic             sat_o
);
  logic [11:0] pat = 12'h000;
  // charges hold one cycle only; a moving pattern otherwise
  always_ff @(posedge clk_i) begin
    pat <= pat + 12'h3c5;
    if (rd_i) begin
      a_o   <= {1'b0, col_i, 3'h0};
      b_o   <= {1'b0, row_i, 4'h0};
      sat_o <= (col_i == 8'h64);
    end else begin
      a_o   <= pat;
      b_o   <= ~pat;
      sat_o <= pat[0];
    end
  end
endmodule : tpa_pix_model
`default_nettype wire
